// file: tb/spu_dec.sv
// Purpose: decoder side model driving the core request ports
// Assumes: called right after a rising pclk edge
// Notes: a request stands until the next call or idle replaces it
`timescale 1ns/100ps
`default_nettype none
module spu_dec
    import spu_pkg::*;
(
    // clock
    input wire logic pclk,
    // requests to the unit
    output var spu_stk_req_s stk_req,
    output var spu_ptr_req_s ptr_req,
    output var spu_reg_wr_s reg_wr,
    output var logic isr_enter,
    output var logic code_fetch_hit
);
    initial
    begin
        stk_req = '0;
        ptr_req = '0;
        reg_wr = '0;
        isr_enter = 1'b0;
        code_fetch_hit = 1'b0;
    end

    task automatic stk(input spu_stk_op_e op, input logic [15:0] d);
        @(posedge pclk);
        stk_req <= '{op, d};
    endtask

    // one access per cycle, so a pointer is never source and target at once
    task automatic ptr(input logic w, input logic [1:0] p, input spu_mod_e m);
        @(posedge pclk);
        ptr_req <= '{1'b1, w, p, m};
    endtask

    // joins the request placed in the same step
    task automatic rw(input logic [3:0] mi, input logic [3:0] si, input logic [15:0] d);
        reg_wr <= '{1'b1, mi, si, d};
    endtask

    task automatic lvl(input logic i, input logic c);
        @(posedge pclk);
        isr_enter <= i;
        code_fetch_hit <= c;
    endtask

    task automatic idle;
        @(posedge pclk);
        stk_req <= '0;
        ptr_req <= '0;
        reg_wr <= '0;
        isr_enter <= 1'b0;
        code_fetch_hit <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: tb/spu_unit_asserts.sv
// Purpose: port checks of the stack and pointer unit
// Assumes: one pclk domain, presetn async low
// Notes: bound to every spu_unit instance
`timescale 1ns/100ps
`default_nettype none
module spu_unit_asserts
    import spu_pkg::*;
#(
    parameter int STACK_DEPTH = 16
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    // stack
    input wire spu_stk_req_s stk_req,
    input wire logic [15:0] stk_top,
    input wire logic ip_load,
    input wire logic [15:0] ip_value,
    input wire logic isr_enter,
    input wire logic isr_active_flag,
    // pointers
    input wire spu_ptr_req_s ptr_req,
    input wire spu_reg_wr_s reg_wr,
    input wire logic code_fetch_hit,
    input wire logic [15:0] rd_addr,
    input wire logic rd_ptr_valid,
    input wire logic [15:0] wr_addr,
    input wire logic wr_en
);
    wire logic apb_wr;
    wire logic ret_op;
    wire logic quiet;
    assign apb_wr = psel && penable && pwrite;
    assign ret_op = stk_req.op == SPU_STK_RET || stk_req.op == SPU_STK_RETI;
    // no other source may select or write a pointer in the same cycle
    assign quiet = !reg_wr.valid && !apb_wr && !code_fetch_hit;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ****************************************
    // stack
    // ****************************************
    sequence s_push_pop;
        stk_req.op == SPU_STK_PUSH ##1 stk_req.op == SPU_STK_POP;
    endsequence

    push_top_a:
        assert property (stk_req.op == SPU_STK_PUSH |=> stk_top == $past(stk_req.data))
        else $error("pushed word not on top");
    push_pop_a:
        assert property (s_push_pop |=> stk_top == $past(stk_top, 2))
        else $error("pop did not restore top");
    ret_load_a:
        assert property (ret_op |=> ip_load && ip_value == $past(stk_top))
        else $error("return value not loaded");
    ip_pulse_a:
        assert property (!ret_op |=> !ip_load)
        else $error("stray load pulse");
    end_clear_a:
        assert property ((stk_req.op == SPU_STK_POP_END || stk_req.op == SPU_STK_RETI)
            && !isr_enter |=> !isr_active_flag)
        else $error("service flag not cleared");

    // ****************************************
    // pointers
    // ****************************************
    wr_strobe_a:
        assert property (wr_en == (ptr_req.valid && ptr_req.write))
        else $error("write strobe wrong");
    wr_select_a:
        assert property (ptr_req.valid && ptr_req.write && quiet
            |=> rd_ptr_valid && rd_addr == $past(wr_addr))
        else $error("write pointer not made active");
    fetch_clear_a:
        assert property (code_fetch_hit && !ptr_req.valid && !reg_wr.valid && !apb_wr
            |=> !rd_ptr_valid)
        else $error("fetch did not drop read pointer");
endmodule

bind spu_unit spu_unit_asserts #(.STACK_DEPTH(STACK_DEPTH)) spu_unit_asserts_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .stk_req(stk_req), .stk_top(stk_top), .ip_load(ip_load), .ip_value(ip_value),
    .isr_enter(isr_enter), .isr_active_flag(isr_active_flag), .ptr_req(ptr_req),
    .reg_wr(reg_wr), .code_fetch_hit(code_fetch_hit), .rd_addr(rd_addr),
    .rd_ptr_valid(rd_ptr_valid), .wr_addr(wr_addr), .wr_en(wr_en)
);
`default_nettype wire

// file: tb/tb_top.sv
// Purpose: self-checking bench of the stack and pointer unit
// Assumes: zero-wait apb slave; spu_dec drives the core ports
// Notes: an idle cycle ends each group of decoder requests
`timescale 1ns/100ps
`default_nettype none
`include "spu_consts.svh"
module tb_top;
    import spu_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, slv;
    logic [15:0] stk_top, ip_value, rd_addr, wr_addr;
    logic ip_load, isr_active_flag, rd_word, rd_ptr_valid, wr_word, wr_en;
    wire spu_stk_req_s stk_req;
    wire spu_ptr_req_s ptr_req;
    wire spu_reg_wr_s reg_wr;
    wire logic isr_enter, code_fetch_hit;
    int fails = 0;
    int n_tests = 0;

    always #4 pclk = ~pclk;

    spu_dec spu_dec_inst (.pclk(pclk), .stk_req(stk_req), .ptr_req(ptr_req),
        .reg_wr(reg_wr), .isr_enter(isr_enter), .code_fetch_hit(code_fetch_hit));

    spu_unit spu_unit_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .stk_req(stk_req),
        .stk_top(stk_top), .ip_load(ip_load), .ip_value(ip_value), .isr_enter(isr_enter),
        .isr_active_flag(isr_active_flag), .ptr_req(ptr_req), .reg_wr(reg_wr),
        .code_fetch_hit(code_fetch_hit), .rd_addr(rd_addr), .rd_word(rd_word),
        .rd_ptr_valid(rd_ptr_valid), .wr_addr(wr_addr), .wr_word(wr_word), .wr_en(wr_en));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {6'h00, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask

    task automatic tick;
        spu_dec_inst.idle();
        #1;
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        #40000;
        fails++;
        give_verdict();
    end

    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(`SPU_OFS_STACK_POINTER, 32'hF);
        rd(`SPU_OFS_POINTER_CONTROL, 32'h0);
        wr(`SPU_OFS_STACK_POINTER, 32'h35);
        rd(`SPU_OFS_STACK_POINTER, 32'h5);
        wr(`SPU_OFS_STACK_POINTER, 32'hE);
        wr(`SPU_OFS_PREFIX_REG, 32'hAB);
        spu_dec_inst.stk(SPU_STK_PUSH, 16'h1111);
        spu_dec_inst.stk(SPU_STK_PUSH, 16'h1234);
        tick();
        chk(32'(stk_top), 32'h1234);
        rd(`SPU_OFS_STACK_POINTER, 32'h0);
        spu_dec_inst.stk(SPU_STK_PUSH_BYTE, 16'hFF56);
        tick();
        chk(32'(stk_top), 32'hAB56);
        spu_dec_inst.stk(SPU_STK_POP, 16'h0);
        tick();
        chk(32'(stk_top), 32'h1234);
        spu_dec_inst.stk(SPU_STK_PUSH, 16'h2222);
        spu_dec_inst.stk(SPU_STK_POP, 16'h0);
        spu_dec_inst.stk(SPU_STK_POP, 16'h0);
        tick();
        chk(32'(stk_top), 32'h1111);
        rd(`SPU_OFS_STACK_POINTER, 32'hF);
        spu_dec_inst.lvl(1'b1, 1'b0);
        tick();
        spu_dec_inst.stk(SPU_STK_PUSH, 16'h3333);
        spu_dec_inst.stk(SPU_STK_POP_END, 16'h0);
        tick();
        chk(32'(isr_active_flag), 32'h0);
        chk(32'(stk_top), 32'h1111);
        spu_dec_inst.stk(SPU_STK_CALL, 16'h0100);
        spu_dec_inst.stk(SPU_STK_RET, 16'h0);
        tick();
        chk(32'(ip_value), 32'h0100);
        spu_dec_inst.lvl(1'b1, 1'b0);
        tick();
        spu_dec_inst.stk(SPU_STK_CALL, 16'h0200);
        spu_dec_inst.stk(SPU_STK_RETI, 16'h0);
        tick();
        chk(32'(ip_value), 32'h0200);
        chk(32'(isr_active_flag), 32'h0);
        wr(`SPU_OFS_DATA_POINTER0, 32'h2345);
        wr(`SPU_OFS_POINTER_CONTROL, 32'h4);
        wr(`SPU_OFS_DATA_POINTER0, 32'h2345);
        wr(`SPU_OFS_POINTER_CONTROL, 32'h0);
        rd(`SPU_OFS_DATA_POINTER0, 32'h468B);
        chk(32'(rd_addr), 32'h468B);
        wr(`SPU_OFS_DATA_POINTER0, 32'hFFFF);
        spu_dec_inst.ptr(1'b0, 2'h0, SPU_MOD_INC);
        tick();
        chk(32'(rd_addr), 32'h0);
        wr(`SPU_OFS_POINTER_CONTROL, 32'h4);
        rd(`SPU_OFS_DATA_POINTER0, 32'h0);
        chk(32'(rd_word), 32'h1);
        spu_dec_inst.ptr(1'b0, 2'h0, SPU_MOD_INC);
        tick();
        chk(32'(rd_addr), 32'h1);
        wr(`SPU_OFS_DATA_POINTER1, 32'h10);
        wr(`SPU_OFS_POINTER_CONTROL, 32'h0);
        spu_dec_inst.ptr(1'b1, 2'h1, SPU_MOD_INC);
        #1;
        chk(32'(wr_addr), 32'h11);
        chk(32'(wr_word), 32'h0);
        tick();
        rd(`SPU_OFS_POINTER_CONTROL, 32'h1);
        chk(32'(rd_addr), 32'h11);
        wr(`SPU_OFS_FRAME_BASE, 32'h100);
        wr(`SPU_OFS_FRAME_DISP, 32'h0);
        rd(`SPU_OFS_POINTER_CONTROL, 32'h2);
        spu_dec_inst.ptr(1'b0, 2'h2, SPU_MOD_DEC);
        tick();
        chk(32'(rd_addr), 32'h1FF);
        rd(`SPU_OFS_FRAME_BASE, 32'h100);
        rd(`SPU_OFS_FRAME_DISP, 32'hFF);
        spu_dec_inst.ptr(1'b1, 2'h2, SPU_MOD_INC);
        #1;
        chk(32'(wr_addr), 32'h100);
        tick();
        spu_dec_inst.lvl(1'b0, 1'b1);
        tick();
        chk(32'(rd_ptr_valid), 32'h0);
        wr(`SPU_OFS_POINTER_CONTROL, 32'h6);
        tick();
        chk(32'(rd_ptr_valid), 32'h1);
        spu_dec_inst.ptr(1'b0, 2'h2, SPU_MOD_INC);
        spu_dec_inst.rw(`SPU_CORE_MODULE, `SPU_SINK_SUB, 16'h5555);
        tick();
        chk(32'(rd_addr), 32'h101);
        rd(`SPU_OFS_DATA_POINTER0, 32'h1);
        spu_dec_inst.lvl(1'b0, 1'b0);
        spu_dec_inst.rw(`SPU_CORE_MODULE, 4'h2, 16'h0042);
        tick();
        rd(`SPU_OFS_POINTER_CONTROL, 32'h4);
        chk(32'(rd_addr), 32'h42);
        rd(6'h1C, 32'h0);
        chk(32'(slv), 32'h1);
        give_verdict();
    end
endmodule
`default_nettype wire

// file: verilog/spu_consts.svh
// Purpose: constants of the stack and data pointer unit
// Assumes: included by the bench and the unit
// Notes: apb byte offsets, field positions, reset values
`ifndef SPU_CONSTS_SVH
`define SPU_CONSTS_SVH

// ****************************************
// register map (byte offsets)
// ****************************************
`define SPU_OFS_STACK_POINTER 6'h00
`define SPU_OFS_POINTER_CONTROL 6'h04
`define SPU_OFS_DATA_POINTER0 6'h08
`define SPU_OFS_DATA_POINTER1 6'h0C
`define SPU_OFS_FRAME_BASE 6'h10
`define SPU_OFS_FRAME_DISP 6'h14
`define SPU_OFS_PREFIX_REG 6'h18
`define SPU_OFS_ISR_ACTIVE 6'h20
`define SPU_OFS_STACK_TOP 6'h24

// ****************************************
// pointer_control fields
// ****************************************
`define SPU_PCTL_SEL_LO 0
`define SPU_PCTL_SEL_HI 1
`define SPU_PCTL_WBS_DP0 2
`define SPU_PCTL_WBS_DP1 3
`define SPU_PCTL_WBS_FP 4

// ****************************************
// reset values and select codes
// ****************************************
`define SPU_SP_RESET 4'hF
`define SPU_PCTL_RESET 5'h00
`define SPU_SEL_DP0 2'h0
`define SPU_SEL_DP1 2'h1
`define SPU_SEL_FP 2'h2

// ****************************************
// core register write port indices
// ****************************************
`define SPU_CORE_MODULE 4'h6
`define SPU_SINK_SUB 4'h7

`endif

// file: verilog/spu_pkg.sv
// Purpose: types of the stack and data pointer unit
// Assumes: nothing
// Notes: request carriers for the decoder ports
package spu_pkg;

    typedef enum logic [2:0]
    {
        SPU_STK_NONE = 3'h0,
        SPU_STK_PUSH = 3'h1,
        SPU_STK_PUSH_BYTE = 3'h2,
        SPU_STK_POP = 3'h3,
        SPU_STK_POP_END = 3'h4,
        SPU_STK_CALL = 3'h5,
        SPU_STK_RET = 3'h6,
        SPU_STK_RETI = 3'h7
    } spu_stk_op_e;

    typedef enum logic [1:0]
    {
        SPU_MOD_NONE = 2'h0,
        SPU_MOD_INC = 2'h1,
        SPU_MOD_DEC = 2'h2
    } spu_mod_e;

    typedef struct packed
    {
        spu_stk_op_e op;
        logic [15:0] data;
    } spu_stk_req_s;

    typedef struct packed
    {
        logic valid;
        logic write;
        logic [1:0] ptr;
        spu_mod_e modify;
    } spu_ptr_req_s;

    typedef struct packed
    {
        logic valid;
        logic [3:0] module_idx;
        logic [3:0] sub_idx;
        logic [15:0] data;
    } spu_reg_wr_s;

endpackage

// file: verilog/spu_unit.sv
// Purpose: hardware stack and data memory pointers of a 16-bit core
// Assumes: decoder requests arrive on pclk; registers over apb
// Notes: zero-wait apb slave, read data captured in the setup cycle
`timescale 1ns/100ps
`default_nettype none
`include "spu_consts.svh"

// Contract
// - stack entries are 16 bits; used by call, return, reti, push, pop
// - push increments stack_pointer first, then writes the addressed entry
// - byte push stores byte low, prefix_reg as high half
// - pop reads the addressed entry, then decrements stack_pointer
// - pop_and_end_service acts as pop and clears isr_active_flag
// - popped top entry feeds the alu directly, decrementing stack_pointer
// - stack_pointer keeps only four written bits; reset value is 0Fh
// - data pointers post-modify on reads, pre-modify on writes
// - frame pointer modifies only frame_displacement, never frame_base
// - word_byte_select bits pick word (1) or byte (0) per pointer
// - word mode addresses 64k words, byte mode 64k bytes
// - data pointers and frame_base are 17 bits; word 16:1, byte 15:0
// - frame_displacement is 9 bits; word uses 8:1, byte 7:0
// - increments and decrements touch only the current mode's bits
// - changing mode leaves the 17 internal bits untouched
// - one read port chosen by source_pointer_select; pointer writes select
// - an indirect memory write makes its pointer the active read pointer
// - active read pointer persists until reselect, code fetch, other write
// - writes to discard_sink at module 6 sub 7 are dropped
// - call pushes return address; return loads instruction pointer from top
module spu_unit
    import spu_pkg::*;
#(
    parameter int STACK_DEPTH = 16
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // decoder: stack
    input wire spu_stk_req_s stk_req,
    output logic [15:0] stk_top,
    output logic ip_load,
    output logic [15:0] ip_value,
    input wire logic isr_enter,
    output logic isr_active_flag,
    // decoder: pointers and register writes
    input wire spu_ptr_req_s ptr_req,
    input wire spu_reg_wr_s reg_wr,
    input wire logic code_fetch_hit,
    // data memory
    output logic [15:0] rd_addr,
    output logic rd_word,
    output logic rd_ptr_valid,
    output logic [15:0] wr_addr,
    output logic wr_word,
    output logic wr_en
);

    if (STACK_DEPTH != 16)
    begin : g_depth_check
        $error("stack depth must match the four-bit stack pointer");
    end

    // ****************************************
    // pointer mode helpers
    // ****************************************
    function automatic logic [15:0] ptr_get(input logic [16:0] p, input logic w);
        ptr_get = w ? p[16:1] : p[15:0];
    endfunction

    function automatic logic [16:0] ptr_put(input logic [16:0] p, input logic w,
                                            input logic [15:0] d);
        ptr_put = w ? {d, p[0]} : {p[16], d};
    endfunction

    function automatic logic [16:0] ptr_step(input logic [16:0] p, input logic w,
                                             input spu_mod_e m);
        logic [15:0] v;
        v = ptr_get(p, w);
        if (m == SPU_MOD_INC)
            v = v + 16'h0001;
        else if (m == SPU_MOD_DEC)
            v = v - 16'h0001;
        ptr_step = ptr_put(p, w, v);
    endfunction

    function automatic logic [8:0] ofs_step(input logic [8:0] p, input logic w,
                                            input spu_mod_e m);
        logic [7:0] v;
        v = w ? p[8:1] : p[7:0];
        if (m == SPU_MOD_INC)
            v = v + 8'h01;
        else if (m == SPU_MOD_DEC)
            v = v - 8'h01;
        ofs_step = w ? {v, p[0]} : {p[8], v};
    endfunction

    // ****************************************
    // state
    // ****************************************
    logic [15:0] stack_mem [STACK_DEPTH];
    logic [3:0] stack_pointer;
    logic [7:0] prefix_reg;
    logic [4:0] pointer_control;
    logic [16:0] data_pointer0;
    logic [16:0] data_pointer1;
    logic [16:0] frame_base;
    logic [8:0] frame_displacement;
    logic [31:0] next_prdata;
    logic [3:0] next_stack_pointer;
    logic [4:0] next_pointer_control;
    logic [16:0] next_data_pointer0;
    logic [16:0] next_data_pointer1;
    logic [16:0] next_frame_base;
    logic [8:0] next_frame_displacement;
    logic next_rd_ptr_valid;

    // ****************************************
    // apb decode
    // ****************************************
    wire logic [5:0] apb_ofs = paddr[5:0];
    wire logic apb_hit = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0) &&
        (apb_ofs <= `SPU_OFS_STACK_TOP) && (apb_ofs != 6'h1C);
    wire logic apb_wr = psel && penable && pwrite && apb_hit;
    wire logic apb_setup_rd = psel && !penable && !pwrite;
    wire logic wr_sp = apb_wr && apb_ofs == `SPU_OFS_STACK_POINTER;
    wire logic wr_pctl = apb_wr && apb_ofs == `SPU_OFS_POINTER_CONTROL;
    wire logic wr_dp0 = apb_wr && apb_ofs == `SPU_OFS_DATA_POINTER0;
    wire logic wr_dp1 = apb_wr && apb_ofs == `SPU_OFS_DATA_POINTER1;
    wire logic wr_base = apb_wr && apb_ofs == `SPU_OFS_FRAME_BASE;
    wire logic wr_disp = apb_wr && apb_ofs == `SPU_OFS_FRAME_DISP;
    wire logic wr_pfx = apb_wr && apb_ofs == `SPU_OFS_PREFIX_REG;
    wire logic wr_isr = apb_wr && apb_ofs == `SPU_OFS_ISR_ACTIVE;

    assign pready = 1'b1;
    assign pslverr = psel && penable && !apb_hit;

    // ****************************************
    // core register write port
    // ****************************************
    // sub-indices follow the apb word index; sub 7 is the bit bucket
    wire logic core_wr = reg_wr.valid && reg_wr.module_idx == `SPU_CORE_MODULE &&
        reg_wr.sub_idx != `SPU_SINK_SUB;
    wire logic cw_dp0 = core_wr && reg_wr.sub_idx == 4'h2;
    wire logic cw_dp1 = core_wr && reg_wr.sub_idx == 4'h3;
    wire logic cw_base = core_wr && reg_wr.sub_idx == 4'h4;
    wire logic cw_disp = core_wr && reg_wr.sub_idx == 4'h5;

    // ****************************************
    // pointer views and memory ports
    // ****************************************
    wire logic wbs0 = pointer_control[`SPU_PCTL_WBS_DP0];
    wire logic wbs1 = pointer_control[`SPU_PCTL_WBS_DP1];
    wire logic wbs2 = pointer_control[`SPU_PCTL_WBS_FP];
    wire logic [1:0] src_sel = pointer_control[`SPU_PCTL_SEL_HI:`SPU_PCTL_SEL_LO];
    wire logic [15:0] dp0_view = ptr_get(data_pointer0, wbs0);
    wire logic [15:0] dp1_view = ptr_get(data_pointer1, wbs1);
    wire logic [15:0] base_view = ptr_get(frame_base, wbs2);
    wire logic [7:0] disp_view = wbs2 ? frame_displacement[8:1] : frame_displacement[7:0];
    wire logic [15:0] fp_view = base_view + {8'h00, disp_view};

    // write pointer after pre-modify
    wire logic [16:0] dp0_pre = ptr_step(data_pointer0, wbs0, ptr_req.modify);
    wire logic [16:0] dp1_pre = ptr_step(data_pointer1, wbs1, ptr_req.modify);
    wire logic [8:0] disp_pre = ofs_step(frame_displacement, wbs2, ptr_req.modify);
    wire logic [7:0] disp_pre_view = wbs2 ? disp_pre[8:1] : disp_pre[7:0];
    wire logic mem_wr = ptr_req.valid && ptr_req.write;
    wire logic mem_rd = ptr_req.valid && !ptr_req.write;

    // word mode spans 64k words, byte mode 64k bytes
    assign rd_addr = src_sel[1] ? fp_view : (src_sel[0] ? dp1_view : dp0_view);
    assign rd_word = src_sel[1] ? wbs2 : (src_sel[0] ? wbs1 : wbs0);
    assign wr_en = mem_wr;
    assign wr_word = ptr_req.ptr[1] ? wbs2 : (ptr_req.ptr[0] ? wbs1 : wbs0);
    assign wr_addr = ptr_req.ptr[1] ? base_view + {8'h00, disp_pre_view} :
        (ptr_req.ptr[0] ? ptr_get(dp1_pre, wbs1) : ptr_get(dp0_pre, wbs0));

    // ****************************************
    // pointer next state
    // ****************************************
    // order: apb write, then core register write, then memory access;
    // the decoder never pairs a modify with a load of the same pointer
    always_comb
    begin
        next_pointer_control = pointer_control;
        next_data_pointer0 = data_pointer0;
        next_data_pointer1 = data_pointer1;
        next_frame_base = frame_base;
        next_frame_displacement = frame_displacement;
        next_rd_ptr_valid = rd_ptr_valid;
        if (code_fetch_hit)
            next_rd_ptr_valid = 1'b0;
        if (wr_pctl)
        begin
            next_pointer_control = pwdata[4:0];
            next_rd_ptr_valid = 1'b1;
        end
        if (wr_dp0 || cw_dp0)
        begin
            next_data_pointer0 = ptr_put(data_pointer0, wbs0,
                cw_dp0 ? reg_wr.data : pwdata[15:0]);
            next_pointer_control[1:0] = `SPU_SEL_DP0;
            next_rd_ptr_valid = 1'b1;
        end
        if (wr_dp1 || cw_dp1)
        begin
            next_data_pointer1 = ptr_put(data_pointer1, wbs1,
                cw_dp1 ? reg_wr.data : pwdata[15:0]);
            next_pointer_control[1:0] = `SPU_SEL_DP1;
            next_rd_ptr_valid = 1'b1;
        end
        if (wr_base || cw_base || wr_disp || cw_disp)
        begin
            if (wr_base || cw_base)
                next_frame_base = ptr_put(frame_base, wbs2,
                    cw_base ? reg_wr.data : pwdata[15:0]);
            if (wr_disp || cw_disp)
            begin
                if (wbs2)
                    next_frame_displacement[8:1] = cw_disp ? reg_wr.data[7:0] : pwdata[7:0];
                else
                    next_frame_displacement[7:0] = cw_disp ? reg_wr.data[7:0] : pwdata[7:0];
            end
            next_pointer_control[1:0] = `SPU_SEL_FP;
            next_rd_ptr_valid = 1'b1;
        end
        if (mem_wr)
        begin
            // the writing pointer becomes the active source pointer
            next_pointer_control[1:0] = ptr_req.ptr[1] ? `SPU_SEL_FP : ptr_req.ptr;
            next_rd_ptr_valid = 1'b1;
        end
        // reads act on the active pointer, writes on the named one
        if (ptr_req.valid)
        begin
            case (mem_wr ? (ptr_req.ptr[1] ? `SPU_SEL_FP : ptr_req.ptr) :
                (src_sel[1] ? `SPU_SEL_FP : src_sel))
                `SPU_SEL_DP0: next_data_pointer0 = dp0_pre;
                `SPU_SEL_DP1: next_data_pointer1 = dp1_pre;
                `SPU_SEL_FP: next_frame_displacement = disp_pre;
                default: next_frame_displacement = frame_displacement;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pointer_control <= `SPU_PCTL_RESET;
            data_pointer0 <= 17'h00000;
            data_pointer1 <= 17'h00000;
            frame_base <= 17'h00000;
            frame_displacement <= 9'h000;
            rd_ptr_valid <= 1'b1;
        end
        else
        begin
            pointer_control <= next_pointer_control;
            data_pointer0 <= next_data_pointer0;
            data_pointer1 <= next_data_pointer1;
            frame_base <= next_frame_base;
            frame_displacement <= next_frame_displacement;
            rd_ptr_valid <= next_rd_ptr_valid;
        end
    end

    // ****************************************
    // stack
    // ****************************************
    wire spu_stk_op_e sop = stk_req.op;
    wire logic is_push = sop == SPU_STK_PUSH || sop == SPU_STK_PUSH_BYTE ||
        sop == SPU_STK_CALL;
    wire logic is_pop = sop == SPU_STK_POP || sop == SPU_STK_POP_END ||
        sop == SPU_STK_RET || sop == SPU_STK_RETI;
    wire logic end_service = sop == SPU_STK_POP_END || sop == SPU_STK_RETI;
    wire logic [3:0] sp_inc = stack_pointer + 4'h1;
    wire logic [15:0] push_word = (sop == SPU_STK_PUSH_BYTE) ?
        {prefix_reg, stk_req.data[7:0]} : stk_req.data;

    // popped value goes straight to the alu operand bus
    assign stk_top = stack_mem[stack_pointer];

    always_comb
    begin
        next_stack_pointer = stack_pointer;
        if (wr_sp)
            next_stack_pointer = pwdata[3:0];
        if (is_push)
            next_stack_pointer = sp_inc;
        else if (is_pop)
            next_stack_pointer = stack_pointer - 4'h1;
    end

    always_ff @(posedge pclk)
    begin
        if (is_push)
            stack_mem[sp_inc] <= push_word;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stack_pointer <= `SPU_SP_RESET;
            prefix_reg <= 8'h00;
            isr_active_flag <= 1'b0;
            ip_load <= 1'b0;
            ip_value <= 16'h0000;
        end
        else
        begin
            stack_pointer <= next_stack_pointer;
            if (wr_pfx)
                prefix_reg <= pwdata[7:0];
            // entry wins over a same-cycle clear
            if (isr_enter)
                isr_active_flag <= 1'b1;
            else if (end_service)
                isr_active_flag <= 1'b0;
            else if (wr_isr)
                isr_active_flag <= pwdata[0];
            ip_load <= sop == SPU_STK_RET || sop == SPU_STK_RETI;
            if (sop == SPU_STK_RET || sop == SPU_STK_RETI)
                ip_value <= stk_top;
        end
    end

    // ****************************************
    // apb read data
    // ****************************************
    always_comb
    begin
        next_prdata = 32'h00000000;
        case (apb_ofs)
            `SPU_OFS_STACK_POINTER: next_prdata = {28'h0000000, stack_pointer};
            `SPU_OFS_POINTER_CONTROL: next_prdata = {27'h0000000, pointer_control};
            `SPU_OFS_DATA_POINTER0: next_prdata = {16'h0000, dp0_view};
            `SPU_OFS_DATA_POINTER1: next_prdata = {16'h0000, dp1_view};
            `SPU_OFS_FRAME_BASE: next_prdata = {16'h0000, base_view};
            `SPU_OFS_FRAME_DISP: next_prdata = {24'h000000, disp_view};
            `SPU_OFS_PREFIX_REG: next_prdata = {24'h000000, prefix_reg};
            `SPU_OFS_ISR_ACTIVE: next_prdata = {31'h00000000, isr_active_flag};
            `SPU_OFS_STACK_TOP: next_prdata = {16'h0000, stk_top};
            default: next_prdata = 32'h00000000;
        endcase
        if (!apb_hit)
            next_prdata = 32'h00000000;
    end

    // captured at the setup edge so prdata comes from a flip-flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (apb_setup_rd)
            prdata <= next_prdata;
    end

endmodule
`default_nettype wire
